// ---- hdl/adcfmt_core.sv ----
// adcfmt_core: pipeline, code format, output arrangement and apb registers
//
// Function
// R1 - encode source stays at or below 210 Msps
// R2 - without stabilizer, each phase at least 2.79 ns
// R3 - encode source stays at or above 1 Msps
// R4 - stabilizer uses rising edge, makes own falling
// R5 - stabilizer holds internal clock at 50 percent
// R6 - relock takes one hundred encode cycles
// R7 - stabilizer on at format levels one and two
// R8 - offset binary: midscale 800, full scale FFF
// R9 - twos complement: offset binary with msb inverted
// R10 - out of range raises flag, clamps code
// R11 - four-level select picks output arrangement
// R12 - demux: two half-rate buses, interleaved or together
// R13 - full rate: every result on bus a
// R14 - result appears five encode cycles after sample
// R15 - format levels zero, one binary; two, three complement
// R16 - bus a data changes just after its clock rises; not the first interleaved word after full rate with the internal clock high
// R17 - each bus has its own overflow flag
// R18 - interleaved mode starts on bus a
//
// Chosen here: the address map and the APB register port.
module adcfmt_core #(
  parameter int PIPE = adcfmt_pkg::PIPE_DEPTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        encode_clock_positive,
  input  wire logic [11:0] sample_code,
  input  wire logic        sample_over,
  input  wire logic        sample_under,
  output logic      [11:0] result_data_bits_a,
  output logic      [11:0] result_data_bits_b,
  output logic             bus_a_overflow_flag,
  output logic             bus_b_overflow_flag,
  output logic             bus_a_output_clock,
  output logic             bus_b_output_clock,
  output logic             result_oe,
  output logic             irq
);

  localparam int DW = adcfmt_pkg::DATA_W;
  localparam int IW = adcfmt_pkg::IRQ_W;

  typedef struct packed {
    logic [1:0]                fmt;
    adcfmt_pkg::adcfmt_mode_type mode;
    logic                      oe;
    logic [IW-1:0]             imask;
    logic [IW-1:0]             istat;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic [PIPE-1:0][DW+1:0]   pipe;   // {over, under, code} per stage
    logic                      phase;  // 0: next word for bus a
    logic [DW:0]               hold;   // {of, code} held for bus a
    logic [DW:0]               pend_a;
    logic [DW:0]               pend_b;
    logic                      commit_a;
    logic                      commit_b;
    logic                      clk_a;
    logic                      clk_b;
    logic [DW-1:0]             dat_a;
    logic [DW-1:0]             dat_b;
    logic                      of_a;
    logic                      of_b;
    logic [DW:0]               last;
    logic                      irq;
  } adcfmt_core_type;

  adcfmt_core_type q_r;
  adcfmt_core_type q_nxt;
  adcfmt_enc_if    enc ();

  logic          acc;
  logic          wr;
  logic          rd;
  logic [DW:0]   word;
  logic [IW-1:0] evt;
  logic          twos;
  logic          demux;

  if (PIPE < 2 || PIPE > 16) begin : g_chk
    $error("adcfmt_core: pipeline depth out of range");
  end

  // encode pin sampling and duty-cycle stabilizer
  adcfmt_clk_track #(
    .CNT_W (16)
  ) u_track (
    .pclk    (pclk),
    .presetn (presetn),
    .enc_pin (encode_clock_positive),
    .enc     (enc)
  );

  // stabilizer only at the two middle levels of the format select
  assign enc.dcs_en = (q_r.fmt == 2'h1) || (q_r.fmt == 2'h2); // [R7]

  // clamp an out-of-range sample and apply the selected code format
  function automatic logic [DW:0] fmt_word(
    input logic [DW+1:0] raw,
    input logic          to_twos
  );
    logic [DW-1:0] code;
    logic          ovf;
    ovf  = raw[DW+1] | raw[DW];                 // [R10]
    code = raw[DW-1:0];                         // [R8]
    if (raw[DW+1]) begin
      code = adcfmt_pkg::CODE_POS;              // [R10]
    end else if (raw[DW]) begin
      code = adcfmt_pkg::CODE_NEG;              // [R10]
    end
    if (to_twos) begin
      code[DW-1] = ~code[DW-1];                 // [R9]
    end
    return {ovf, code};
  endfunction : fmt_word

  // next state of bus slave, pipeline, output buses and interrupts
  always_comb begin
    q_nxt    = q_r;
    twos     = q_r.fmt[1];                      // [R15]
    demux    = (q_r.mode == adcfmt_pkg::MODE_SIM) ||
               (q_r.mode == adcfmt_pkg::MODE_ILV);
    word     = fmt_word(q_r.pipe[PIPE-1], twos);
    evt      = '0;
    acc      = psel & penable & q_r.pready;
    wr       = acc & pwrite;
    rd       = psel & penable & ~q_r.pready & ~pwrite;

    // apb: one wait state, then a one-cycle ready
    q_nxt.pready  = psel & penable & ~q_r.pready;
    q_nxt.pslverr = 1'b0;
    if (psel & penable & ~q_r.pready) begin
      unique case (paddr)
        adcfmt_pkg::ADDR_CTRL, adcfmt_pkg::ADDR_STAT,
        adcfmt_pkg::ADDR_ISTAT, adcfmt_pkg::ADDR_IMASK,
        adcfmt_pkg::ADDR_LAST: q_nxt.pslverr = 1'b0;
        default:               q_nxt.pslverr = 1'b1;
      endcase
    end
    q_nxt.prdata = '0;
    if (rd) begin
      unique case (paddr)
        adcfmt_pkg::ADDR_CTRL: begin
          q_nxt.prdata[adcfmt_pkg::CTRL_FMT_LSB +: 2]  = q_r.fmt;
          q_nxt.prdata[adcfmt_pkg::CTRL_MODE_LSB +: 2] = q_r.mode;
          q_nxt.prdata[adcfmt_pkg::CTRL_OE_BIT]        = q_r.oe;
        end
        adcfmt_pkg::ADDR_STAT: begin
          q_nxt.prdata[adcfmt_pkg::STAT_LOCK_BIT] = enc.locked;
          q_nxt.prdata[adcfmt_pkg::STAT_RUN_BIT]  = ~enc.stopped;
          q_nxt.prdata[adcfmt_pkg::STAT_DCS_BIT]  = enc.dcs_en;
          q_nxt.prdata[adcfmt_pkg::STAT_TWOS_BIT] = twos;
        end
        adcfmt_pkg::ADDR_ISTAT: q_nxt.prdata[IW-1:0] = q_r.istat;
        adcfmt_pkg::ADDR_IMASK: q_nxt.prdata[IW-1:0] = q_r.imask;
        adcfmt_pkg::ADDR_LAST:  q_nxt.prdata[DW:0]   = q_r.last;
        default:                q_nxt.prdata         = '0;
      endcase
    end
    if (wr && paddr == adcfmt_pkg::ADDR_CTRL) begin
      q_nxt.fmt   = pwdata[adcfmt_pkg::CTRL_FMT_LSB +: 2];
      q_nxt.mode  = adcfmt_pkg::adcfmt_mode_type'(
                      pwdata[adcfmt_pkg::CTRL_MODE_LSB +: 2]); // [R11]
      q_nxt.oe    = pwdata[adcfmt_pkg::CTRL_OE_BIT];
      q_nxt.phase = 1'b0;                       // [R18]
    end
    if (wr && paddr == adcfmt_pkg::ADDR_IMASK) begin
      q_nxt.imask = pwdata[IW-1:0];
    end

    // commit pending words one cycle after bus a clock rose, or bus b clock in interleaved mode
    q_nxt.commit_a = 1'b0;
    q_nxt.commit_b = 1'b0;
    if (q_r.commit_a) begin
      q_nxt.dat_a = q_r.pend_a[DW-1:0];         // [R16]
      q_nxt.of_a  = q_r.pend_a[DW];             // [R17]
    end
    if (q_r.commit_b) begin
      q_nxt.dat_b = q_r.pend_b[DW-1:0];
      q_nxt.of_b  = q_r.pend_b[DW];             // [R17]
    end

    // each encode tick: emit the oldest stage, shift in a new sample
    if (enc.tick) begin
      q_nxt.pipe = {q_r.pipe[PIPE-2:0],
                    {sample_over, sample_under, sample_code}}; // [R14]
      q_nxt.last = word;
      evt[adcfmt_pkg::IRQ_OVF_BIT] = word[DW];
      unique case (q_r.mode)
        adcfmt_pkg::MODE_FULL, adcfmt_pkg::MODE_LVDS: begin
          q_nxt.pend_a   = word;                // [R13]
          q_nxt.commit_a = 1'b1;
        end
        adcfmt_pkg::MODE_ILV: begin
          q_nxt.phase = ~q_r.phase;             // [R12]
          if (!q_r.phase) begin
            q_nxt.pend_a   = word;              // [R18]
            q_nxt.commit_a = 1'b1;
            q_nxt.clk_a    = 1'b1;
          end else begin
            q_nxt.pend_b   = word;              // [R12]
            q_nxt.commit_b = 1'b1;
            q_nxt.clk_a    = 1'b0;
          end
        end
        adcfmt_pkg::MODE_SIM: begin
          q_nxt.phase = ~q_r.phase;
          if (!q_r.phase) begin
            q_nxt.hold  = word;
            q_nxt.clk_a = 1'b0;
          end else begin
            q_nxt.pend_a   = q_r.hold;          // [R12]
            q_nxt.pend_b   = word;
            q_nxt.commit_a = 1'b1;
            q_nxt.commit_b = 1'b1;
            q_nxt.clk_a    = 1'b1;
          end
        end
      endcase
    end

    // a control write drops a word in flight and, from a demux arrangement, lowers bus a clock,
    // so the first commit in a new arrangement follows a fresh rise, except full rate into interleaved mode with the internal clock high
    if (wr && paddr == adcfmt_pkg::ADDR_CTRL) begin
      q_nxt.phase    = 1'b0;                    // [R18]
      q_nxt.clk_a    = 1'b0;                    // [R16]
      q_nxt.commit_a = 1'b0;
      q_nxt.commit_b = 1'b0;
    end

    // full rate follows the internal clock; b clock opposes a in demux
    if (!demux) begin
      q_nxt.clk_a = enc.iclk;                   // [R16]
      q_nxt.clk_b = 1'b0;
      q_nxt.dat_b = '0;
      q_nxt.of_b  = 1'b0;
    end else begin
      q_nxt.clk_b = ~q_nxt.clk_a;
    end

    // a stopped clock or disabled outputs restart demux on bus a
    if (enc.stopped || !q_r.oe) begin
      q_nxt.phase = 1'b0;                       // [R18]
      q_nxt.clk_a = 1'b0;
      q_nxt.clk_b = 1'b0;
    end

    // disabled outputs hold words and flags low from the register
    if (!q_r.oe) begin
      q_nxt.dat_a = '0;
      q_nxt.dat_b = '0;
      q_nxt.of_a  = 1'b0;
      q_nxt.of_b  = 1'b0;
    end

    // sticky interrupt status: a new event wins over a clear
    evt[adcfmt_pkg::IRQ_LOCK_BIT] = enc.lock_evt;
    evt[adcfmt_pkg::IRQ_STOP_BIT] = enc.stop_evt;
    if (wr && paddr == adcfmt_pkg::ADDR_ISTAT) begin
      q_nxt.istat = q_r.istat & ~pwdata[IW-1:0];
    end
    q_nxt.istat = q_nxt.istat | evt;
    q_nxt.irq   = |(q_nxt.istat & q_nxt.imask);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r       <= '0;
      q_r.fmt   <= adcfmt_pkg::RST_FMT;
      q_r.mode  <= adcfmt_pkg::adcfmt_mode_type'(adcfmt_pkg::RST_MODE);
      q_r.oe    <= adcfmt_pkg::RST_OE;
      q_r.imask <= adcfmt_pkg::RST_IMASK;
    end else begin
      q_r <= q_nxt;
    end
  end

  // all outputs come straight from the state register
  assign prdata              = q_r.prdata;
  assign pready              = q_r.pready;
  assign pslverr             = q_r.pslverr;
  assign result_data_bits_a  = q_r.dat_a;
  assign result_data_bits_b  = q_r.dat_b;
  assign bus_a_overflow_flag = q_r.of_a;
  assign bus_b_overflow_flag = q_r.of_b;
  assign bus_a_output_clock  = q_r.clk_a;
  assign bus_b_output_clock  = q_r.clk_b;
  assign result_oe           = q_r.oe;
  assign irq                 = q_r.irq;

endmodule : adcfmt_core

// ---- pkg/adcfmt_pkg.sv ----
// adcfmt_pkg: shared constants and types of the encode and output formatter
package adcfmt_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_ISTAT = 8'h08;
  localparam logic [7:0] ADDR_IMASK = 8'h0C;
  localparam logic [7:0] ADDR_LAST  = 8'h10;

  // control field positions
  localparam int CTRL_FMT_LSB  = 0;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_OE_BIT   = 4;

  // status field positions
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_RUN_BIT  = 1;
  localparam int STAT_DCS_BIT  = 2;
  localparam int STAT_TWOS_BIT = 3;

  // interrupt bit positions
  localparam int IRQ_OVF_BIT  = 0;
  localparam int IRQ_LOCK_BIT = 1;
  localparam int IRQ_STOP_BIT = 2;
  localparam int IRQ_W        = 3;

  // reset values
  localparam logic [1:0]       RST_FMT   = 2'h0;
  localparam logic [1:0]       RST_MODE  = 2'h0;
  localparam logic             RST_OE    = 1'b1;
  localparam logic [IRQ_W-1:0] RST_IMASK = 3'h0;

  // result word layout and extreme codes
  localparam int               DATA_W   = 12;
  localparam logic [DATA_W-1:0] CODE_POS = 12'hFFF;
  localparam logic [DATA_W-1:0] CODE_NEG = 12'h000;

  // timing: pipeline depth, relock count, slowest legal encode period
  localparam int PIPE_DEPTH     = 5;
  localparam int LOCK_CYCLES    = 100;
  localparam int CLK_MHZ        = 40;
  localparam int MIN_RATE_PER_NS = 1000;
  localparam int STOP_CYC       = (MIN_RATE_PER_NS * CLK_MHZ) / 1000;

  // four-level output arrangement select
  typedef enum logic [1:0] {
    MODE_FULL = 2'h0,
    MODE_SIM  = 2'h1,
    MODE_ILV  = 2'h2,
    MODE_LVDS = 2'h3
  } adcfmt_mode_type;

  // encode tracker state, gray along stop, locking, locked
  typedef enum logic [1:0] {
    TRK_STOP  = 2'h0,
    TRK_LOCKG = 2'h1,
    TRK_LOCKD = 2'h3
  } adcfmt_trk_type;

endpackage : adcfmt_pkg

// ---- pkg/adcfmt_enc_if.sv ----
// adcfmt_enc_if: encode tracker to formatter core signals
interface adcfmt_enc_if;
  logic tick;     // one pclk pulse per encode rising edge
  logic iclk;     // internal encode clock level
  logic locked;   // stabilizer locked, or clock running with the stabilizer off
  logic stopped;  // encode clock seen stopped
  logic lock_evt; // pulse on entering lock
  logic stop_evt; // pulse on detecting a stop
  logic dcs_en;   // duty-cycle stabilizer enabled

  modport trk (
    input  dcs_en,
    output tick,
    output iclk,
    output locked,
    output stopped,
    output lock_evt,
    output stop_evt
  );

  modport core (
    output dcs_en,
    input  tick,
    input  iclk,
    input  locked,
    input  stopped,
    input  lock_evt,
    input  stop_evt
  );
endinterface : adcfmt_enc_if

// ---- hdl/adcfmt_clk_track.sv ----
// adcfmt_clk_track: encode pin sampling, edge finding and duty stabilizer
module adcfmt_clk_track #(
  parameter int CNT_W = 16
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   enc_pin,
  adcfmt_enc_if.trk   enc
);

  typedef struct packed {
    logic [2:0]             sync;
    logic                   lvl;
    adcfmt_pkg::adcfmt_trk_type st;
    logic [CNT_W-1:0]       cnt;
    logic [CNT_W-1:0]       period;
    logic [6:0]             locks;
    logic                   iclk;
    logic                   tick;
    logic                   lock_evt;
    logic                   stop_evt;
  } adcfmt_trkst_type;

  adcfmt_trkst_type q_r;
  adcfmt_trkst_type q_nxt;
  logic             rise;

  if (adcfmt_pkg::LOCK_CYCLES > 127 ||
      adcfmt_pkg::STOP_CYC >= (1 << CNT_W) - 1) begin : g_chk
    $error("adcfmt_clk_track: counter widths too small");
  end

  // next state: sync, filtered level, period, lock and internal clock
  always_comb begin
    q_nxt          = q_r;
    rise           = 1'b0;
    q_nxt.sync     = {q_r.sync[1:0], enc_pin};
    q_nxt.tick     = 1'b0;
    q_nxt.lock_evt = 1'b0;
    q_nxt.stop_evt = 1'b0;
    if (q_r.sync[1] == q_r.sync[2]) begin
      q_nxt.lvl = q_r.sync[2];
    end
    rise = q_nxt.lvl & ~q_r.lvl;
    if (rise) begin
      q_nxt.period = q_r.cnt + 1'b1; // pclk cycles per encode cycle
      q_nxt.cnt    = '0;
      q_nxt.tick   = 1'b1;
    end else if (q_r.cnt != {CNT_W{1'b1}}) begin
      q_nxt.cnt = q_r.cnt + 1'b1;
    end
    // only the rising edge counts, falling edge made at half period
    if (enc.dcs_en) begin
      if (rise) begin
        q_nxt.iclk = 1'b1; // [R4]
      end else if (q_nxt.cnt >= {1'b0, q_r.period[CNT_W-1:1]}) begin
        q_nxt.iclk = 1'b0; // [R4] [R5]
      end
    end else begin
      q_nxt.iclk = q_nxt.lvl;
    end
    // lock tracking: relock needs a full run of encode cycles
    unique case (q_r.st)
      adcfmt_pkg::TRK_STOP: begin
        if (rise) begin
          q_nxt.st    = adcfmt_pkg::TRK_LOCKG;
          q_nxt.locks = '0;
        end
      end
      adcfmt_pkg::TRK_LOCKG: begin
        if (rise) begin
          q_nxt.locks = q_r.locks + 1'b1;
          if (q_r.locks == 7'(adcfmt_pkg::LOCK_CYCLES - 1)) begin
            q_nxt.st       = adcfmt_pkg::TRK_LOCKD; // [R6]
            q_nxt.lock_evt = 1'b1;
          end
        end
      end
      adcfmt_pkg::TRK_LOCKD: begin
      end
    endcase
    // no edge for longer than the slowest legal rate means stopped
    if (q_r.st != adcfmt_pkg::TRK_STOP &&
        q_r.cnt == CNT_W'(adcfmt_pkg::STOP_CYC)) begin // [R3]
      q_nxt.st       = adcfmt_pkg::TRK_STOP; // [R6]
      q_nxt.stop_evt = 1'b1;
      q_nxt.iclk     = 1'b0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs to the core
  assign enc.tick     = q_r.tick;
  assign enc.iclk     = q_r.iclk;
  assign enc.locked   = (q_r.st == adcfmt_pkg::TRK_LOCKD) ||
                        (!enc.dcs_en && q_r.st != adcfmt_pkg::TRK_STOP);
  assign enc.stopped  = (q_r.st == adcfmt_pkg::TRK_STOP);
  assign enc.lock_evt = q_r.lock_evt;
  assign enc.stop_evt = q_r.stop_evt;

endmodule : adcfmt_clk_track

// ---- tb/adcfmt_props.sv ----
// adcfmt_props: port assertions for the encode and output formatter
module adcfmt_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic [11:0] result_data_bits_a,
  input logic [11:0] result_data_bits_b,
  input logic        bus_a_overflow_flag,
  input logic        bus_b_overflow_flag,
  input logic        bus_a_output_clock,
  input logic        bus_b_output_clock,
  input logic        result_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // apb answer one cycle after the access phase, one cycle long
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata outside answer");

  // a flagged word sits at an extreme code of either format
  a_clamp_bus_a: assert property (
    bus_a_overflow_flag |-> result_data_bits_a inside
      {12'hFFF, 12'h000, 12'h7FF, 12'h800})
    else $error("bus a flagged word not clamped");
  a_clamp_bus_b: assert property (
    bus_b_overflow_flag |-> result_data_bits_b inside
      {12'hFFF, 12'h000, 12'h7FF, 12'h800})
    else $error("bus b flagged word not clamped");

  // bus a word and flag change just after its clock rose
  a_a_after_clk: assert property (
    ($changed(result_data_bits_a) || $changed(bus_a_overflow_flag)) &&
    result_oe && $past(result_oe) && $past(result_oe, 2) |->
    $past(bus_a_output_clock) && !$past(bus_a_output_clock, 2))
    else $error("bus a changed off its clock edge");

  // a disabled output drives both words, both clocks and the bus a flag low
  a_oe_quiet: assert property (!result_oe && !$past(result_oe) |->
    result_data_bits_a == 12'h000 && result_data_bits_b == 12'h000 &&
    !bus_a_output_clock && !bus_b_output_clock && !bus_a_overflow_flag)
    else $error("outputs active while disabled");

  // main scenarios reached
  c_refused: cover property (pready && pslverr);
  c_flagged: cover property (bus_a_overflow_flag);
  c_disabled: cover property (!result_oe);
  c_bus_b: cover property ($rose(bus_b_output_clock));
endmodule : adcfmt_props

bind adcfmt_core adcfmt_props i_props (.*);

// ---- tb/adcfmt_capture.sv ----
// adcfmt_capture: capture logic latching the converter output buses
module adcfmt_capture (
  input  logic        clk_a,
  input  logic        clk_b,
  input  logic        b_on_rise,
  input  logic [11:0] data_a,
  input  logic [11:0] data_b,
  output logic [11:0] cap_a,
  output logic [11:0] cap_b,
  output int          n_b
);
  timeunit 1ns;
  timeprecision 1ps;

  initial n_b = 0;

  // bus a latched on the falling edge of its clock
  always @(negedge clk_a) begin
    cap_a <= data_a;
  end

  // bus b on its falling edge, or rising edge when updated together
  always @(clk_b) begin
    if (clk_b === b_on_rise) begin
      cap_b <= data_b;
      n_b <= n_b + 1;
    end
  end
endmodule : adcfmt_capture

// ---- tb/tb.sv ----
// tb: self-checking bench for the encode and output formatter
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er, irq, result_oe;
  logic        encode_clock_positive, sample_over, sample_under;
  logic [11:0] sample_code, result_data_bits_a, result_data_bits_b;
  logic        bus_a_overflow_flag, bus_b_overflow_flag;
  logic        bus_a_output_clock, bus_b_output_clock;
  logic [11:0] cap_a, cap_b, last;
  logic        enc_run, inc, b_on_rise;
  int          miscompares, num_checks, n_b;

  adcfmt_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .encode_clock_positive,
    .sample_code, .sample_over, .sample_under, .result_data_bits_a,
    .result_data_bits_b, .bus_a_overflow_flag, .bus_b_overflow_flag,
    .bus_a_output_clock, .bus_b_output_clock, .result_oe, .irq);

  adcfmt_capture i_cap (.clk_a(bus_a_output_clock),
    .clk_b(bus_b_output_clock), .b_on_rise, .data_a(result_data_bits_a),
    .data_b(result_data_bits_b), .cap_a, .cap_b, .n_b);

  // bench clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // encode source: 5 Msps, even duty, standing still while stopped
  initial begin
    encode_clock_positive = 1'b0;
    #7;
    forever begin
      if (enc_run) begin
        #100 encode_clock_positive = 1'b1;
        #100 encode_clock_positive = 1'b0;
      end else begin
        #25;
      end
    end
  end

  // next sample set mid-low, clear of the encode tick
  always @(negedge encode_clock_positive) begin
    if (inc) begin
      repeat (2) @(posedge pclk);
      sample_code <= sample_code + 12'h001;
    end
  end

  // hang guard
  initial begin
    #1000000;
    miscompares++;
    give_verdict();
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      give_verdict();
    end
  endtask : apb

  task automatic edges(input int n);
    repeat (n) @(posedge encode_clock_positive);
  endtask : edges

  task automatic drive(input logic [11:0] c, input logic o, input logic u);
    @(posedge pclk);
    sample_code <= c;
    sample_over <= o;
    sample_under <= u;
  endtask : drive

  // poll status until the encode tracker reports lock
  task automatic wait_lock();
    int n;
    n = 0;
    do begin
      apb(1'b0, adcfmt_pkg::ADDR_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 400);
    check("locked", 32'h1, rd[0]);
  endtask : wait_lock

  // expected word: clamp, then msb inverted for twos complement
  function automatic logic [11:0] fmt_code(int f, logic [11:0] c,
                                           logic o, logic u);
    logic [11:0] v;
    v = o ? 12'hFFF : (u ? 12'h000 : c);
    v[11] = v[11] ^ (f >= 2);
    return v;
  endfunction : fmt_code

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sample_code = 12'h000;
    sample_over = 1'b0;
    sample_under = 1'b0;
    enc_run = 1'b1;
    inc = 1'b0;
    b_on_rise = 1'b0;
    miscompares = 0;
    num_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, adcfmt_pkg::ADDR_CTRL, 32'h0);
    check("ctrl reset", 32'h10, rd);
    apb(1'b0, adcfmt_pkg::ADDR_IMASK, 32'h0);
    check("imask reset", 32'h0, rd);
    apb(1'b1, 8'h14, 32'h1);
    check("unmapped", 32'h1, er);
    // every format level, in range, over and under
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, adcfmt_pkg::ADDR_CTRL, 32'h10 | f);
      wait_lock();
      check("stabilizer", (f == 1 || f == 2), rd[2]);
      check("twos", f >= 2, rd[3]);
      for (int e = 0; e < 3; e++) begin
        drive(12'h3C5, e == 0, e == 1);
        edges(8);
        check("word", fmt_code(f, 12'h3C5, e == 0, e == 1),
              result_data_bits_a);
        check("flag", e < 2, bus_a_overflow_flag);
      end
    end
    // overflow interrupt: masked, raised, cleared
    apb(1'b0, adcfmt_pkg::ADDR_ISTAT, 32'h0);
    check("ovf event", 32'h1, rd[0]);
    check("irq masked", 32'h0, irq);
    apb(1'b1, adcfmt_pkg::ADDR_IMASK, 32'h1);
    apb(1'b0, adcfmt_pkg::ADDR_IMASK, 32'h0);
    check("irq raised", 32'h1, irq);
    apb(1'b1, adcfmt_pkg::ADDR_ISTAT, 32'h1);
    apb(1'b0, adcfmt_pkg::ADDR_ISTAT, 32'h0);
    check("ovf cleared", 32'h0, rd[0]);
    check("irq cleared", 32'h0, irq);
    // stop the encode clock, then relock with the stabilizer
    apb(1'b1, adcfmt_pkg::ADDR_CTRL, 32'h11);
    enc_run = 1'b0;
    repeat (120) @(posedge pclk);
    apb(1'b0, adcfmt_pkg::ADDR_ISTAT, 32'h0);
    check("stop event", 32'h1, rd[2]);
    apb(1'b0, adcfmt_pkg::ADDR_STAT, 32'h0);
    check("unlocked", 32'h0, rd[0]);
    enc_run = 1'b1;
    edges(90);
    apb(1'b0, adcfmt_pkg::ADDR_STAT, 32'h0);
    check("lock early", 32'h0, rd[0]);
    edges(16);
    apb(1'b0, adcfmt_pkg::ADDR_STAT, 32'h0);
    check("relocked", 32'h1, rd[0]);
    // pipeline latency, full rate offset binary
    apb(1'b1, adcfmt_pkg::ADDR_CTRL, 32'h10);
    drive(12'h111, 1'b0, 1'b0);
    edges(8);
    @(negedge encode_clock_positive);
    @(posedge pclk);
    drive(12'h222, 1'b0, 1'b0);
    edges(6);
    check("before five", 32'h111, result_data_bits_a);
    edges(1);
    check("after five", 32'h222, result_data_bits_a);
    @(negedge bus_a_output_clock);
    @(posedge pclk);
    check("captured", 32'h222, cap_a);
    // every output arrangement with a rising sample stream
    inc = 1'b1;
    for (int m = 0; m < 4; m++) begin
      b_on_rise = (m == 1);
      apb(1'b1, adcfmt_pkg::ADDR_CTRL, 32'h10 | (m << 2));
      edges(12);
      for (int r = 0; r < 3; r++) begin
        last = cap_a;
        if (m == 1 || m == 2) begin
          @(n_b);
          @(posedge pclk);
          check("b follows a", cap_a + 12'h001, cap_b);
        end else begin
          @(negedge bus_a_output_clock);
          @(posedge pclk);
          check("a step", last + 12'h001, cap_a);
          check("b idle", 32'h0, result_data_bits_b);
          check("b flag", 32'h0, bus_b_overflow_flag);
        end
      end
    end
    // output disable
    apb(1'b1, adcfmt_pkg::ADDR_CTRL, 32'h0);
    edges(2);
    check("quiet", 32'h0, {bus_a_output_clock, result_data_bits_a});
    give_verdict();
  end
endmodule : tb
